/* File: hdl/lcg_compat_top.sv */
// legacy compatibility gating, gpio ports a..g and the reduced-feature control words
// assumes an avalon-mm master on mclk_in and a fuse level that is static while powered
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module lcg_compat_top (
  input  wire logic                                     mclk_in,
  input  wire logic                                     rst_n_in,
  input  wire logic                                     ce_in,
  input  wire logic                                     legacy_compat_fuse_in,
  input  wire logic [lcg_pkg::ADDR_W-1:0]               avs_address_in,
  input  wire logic                                     avs_read_in,
  input  wire logic                                     avs_write_in,
  input  wire logic [lcg_pkg::DATA_W-1:0]               avs_writedata_in,
  input  wire logic [3:0]                               avs_byteenable_in,
  output logic      [lcg_pkg::DATA_W-1:0]               avs_readdata_out,
  output logic                                          avs_waitrequest_out,
  input  wire logic [lcg_pkg::NUM_PORTS-1:0][7:0]       gpio_pin_in,
  output logic      [lcg_pkg::NUM_PORTS-1:0][7:0]       gpio_out_out,
  output logic      [lcg_pkg::NUM_PORTS-1:0][7:0]       gpio_oe_n_out,
  output logic      [lcg_pkg::NUM_PORTS-1:0][7:0]       gpio_pullup_out,
  input  wire logic [lcg_pkg::PORTG_W-1:0]              portg_pin_in,
  output logic      [lcg_pkg::PORTG_W-1:0]              portg_out_out,
  output logic      [lcg_pkg::PORTG_W-1:0]              portg_oe_n_out,
  output logic      [lcg_pkg::PORTG_W-1:0]              portg_pullup_out,
  input  wire logic                                     xmem_wr_n_in,
  input  wire logic                                     xmem_rd_n_in,
  input  wire logic                                     xmem_ale_in,
  input  wire lcg_pkg::lcg_rst_flags_t                  rst_event_in,
  output lcg_pkg::lcg_features_t                        features_out,
  output logic      [lcg_pkg::BAUD_W-1:0]               baud_div_out,
  output logic      [7:0]                               osc_cal_out,
  output logic                                          wdt_enable_out,
  output logic      [lcg_pkg::WDT_PS_W-1:0]             wdt_prescale_out,
  output logic      [lcg_pkg::EINT_W-1:0]               ext_int_sense_out,
  output logic      [lcg_pkg::XREL_W-1:0]               xmem_release_out,
  output logic                                          xmem_sect_ws_en_out
);

  // mode and feature state
  logic                  mode_ff, nxt_mode;
  lcg_pkg::lcg_features_t feat_ff, nxt_feat;
  logic                  in_reset;
  logic                  mode_now;

  // bus slave state
  logic                        wait_ff, nxt_wait;
  logic [lcg_pkg::DATA_W-1:0]  rdata_ff, nxt_rdata;
  logic [lcg_pkg::DATA_W-1:0]  rd_mux;
  logic                        req;
  logic                        wr_go;
  logic                        lane0;
  logic                        lane1;
  logic                        port_hit;
  logic [2:0]                  port_idx;
  logic [1:0]                  port_ofs;

  // control words
  lcg_pkg::lcg_rst_flags_t      rstf_ff, nxt_rstf;
  logic [lcg_pkg::BAUD_W-1:0]   baud_ff, nxt_baud;
  logic [7:0]                   osc_ff, nxt_osc;
  logic                         wdt_en_ff, nxt_wdt_en;
  logic [lcg_pkg::WDT_PS_W-1:0] wdt_ps_ff, nxt_wdt_ps;
  lcg_pkg::lcg_wdt_state_t      wdt_st_ff, nxt_wdt_st;
  logic [2:0]                   wdt_cnt_ff, nxt_wdt_cnt;
  logic [lcg_pkg::EINT_W-1:0]   eint_ff, nxt_eint;
  logic [lcg_pkg::XREL_W-1:0]   xrel_ff, nxt_xrel;
  logic                         xws_ff, nxt_xws;

  // port latch views
  logic [lcg_pkg::NUM_PORTS-1:0][7:0] p_out, p_dir, p_pin, p_dir_eff;
  logic [lcg_pkg::NUM_PORTS-1:0]      p_out_we, p_dir_we;
  logic [lcg_pkg::PORTG_W-1:0]        g_out, g_dir, g_pin;
  logic                               g_out_we, g_dir_we;

  // the fuse is read live only while reset holds; after release the sampled mode rules
  assign in_reset = !rst_n_in;
  assign mode_now = in_reset ? legacy_compat_fuse_in : mode_ff;  // [RULE_01]

  // mode capture and derived feature set
  always_comb begin
    nxt_mode = in_reset ? legacy_compat_fuse_in : mode_ff;  // [RULE_20]
    // legacy mode clears every extended feature enable
    nxt_feat = mode_ff ? lcg_pkg::FEAT_LEGACY : lcg_pkg::FEAT_NORMAL;  // [RULE_02] [RULE_03]
    // also gates twi, boot, osc trim, rx fifo and extended io/vectors
    // [RULE_04] [RULE_08] [RULE_09] [RULE_14] [RULE_18]
  end

  // mode is sampled in reset on purpose: a fuse change mid-run must not reshape the ports
  always_ff @(posedge mclk_in) begin
    if (ce_in) begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      feat_ff <= lcg_pkg::FEAT_LEGACY;
    end else if (ce_in) begin
      feat_ff <= nxt_feat;
    end
  end

  // bus decode
  assign req      = avs_read_in | avs_write_in;
  assign wr_go    = avs_write_in & !wait_ff;
  assign lane0    = avs_byteenable_in[0];
  assign lane1    = avs_byteenable_in[1];
  assign port_idx = avs_address_in[6:4];
  assign port_ofs = avs_address_in[3:2];
  assign port_hit = !avs_address_in[7] && (port_idx <= lcg_pkg::PORT_G_IDX)
                    && (port_ofs != 2'h3);

  // port write strobes, gated by what legacy mode still lets software change
  always_comb begin
    for (int i = 0; i < lcg_pkg::NUM_PORTS; i++) begin
      p_out_we[i] = wr_go & lane0 & port_hit & (port_idx == 3'(i))
                    & (port_ofs == lcg_pkg::OFS_OUT);
      p_dir_we[i] = wr_go & lane0 & port_hit & (port_idx == 3'(i))
                    & (port_ofs == lcg_pkg::OFS_DIR);
    end
    g_out_we = wr_go & lane0 & port_hit & (port_idx == lcg_pkg::PORT_G_IDX)
               & (port_ofs == lcg_pkg::OFS_OUT) & !mode_ff;  // [RULE_06]
    g_dir_we = wr_go & lane0 & port_hit & (port_idx == lcg_pkg::PORT_G_IDX)
               & (port_ofs == lcg_pkg::OFS_DIR) & !mode_ff;  // [RULE_06]
  end

  // ports a..f share one latch module; legacy forcing happens on the pin side
  for (genvar gi = 0; gi < lcg_pkg::NUM_PORTS; gi++) begin : g_port
    lcg_gpio_port #(
      .W       (lcg_pkg::PORT_W),
      .OUT_RST (lcg_pkg::PORT_ZERO),
      .DIR_RST (lcg_pkg::PORT_ZERO)
    ) u_port (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .ce_in       (ce_in),
      .out_we_in   (p_out_we[gi]),
      .dir_we_in   (p_dir_we[gi]),
      .wdata_in    (avs_writedata_in[7:0]),
      .pin_in      (gpio_pin_in[gi]),
      .out_val_out (p_out[gi]),
      .dir_val_out (p_dir[gi]),
      .pin_val_out (p_pin[gi])
    );
  end

  lcg_gpio_port #(
    .W       (lcg_pkg::PORTG_W),
    .OUT_RST (lcg_pkg::PORT_ZERO),
    .DIR_RST (lcg_pkg::PORT_ZERO)
  ) u_port_g (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .out_we_in   (g_out_we),
    .dir_we_in   (g_dir_we),
    .wdata_in    (avs_writedata_in[4:0]),
    .pin_in      (portg_pin_in),
    .out_val_out (g_out),
    .dir_val_out (g_dir),
    .pin_val_out (g_pin)
  );

  // pin drive is combinational from reset so the pads float (legacy port c and port g 2..0 drive) with no clock edge
  always_comb begin
    for (int i = 0; i < lcg_pkg::NUM_PORTS; i++) begin
      p_dir_eff[i] = p_dir[i];  // [RULE_16]
      if (mode_now && (3'(i) == lcg_pkg::PORT_C_IDX)) begin
        p_dir_eff[i] = lcg_pkg::PORT_ONES;  // [RULE_05]
      end
      if (mode_now && (3'(i) == lcg_pkg::PORT_F_IDX)) begin
        p_dir_eff[i] = lcg_pkg::PORT_ZERO;  // [RULE_07]
      end
      gpio_out_out[i]  = p_out[i];
      gpio_oe_n_out[i] = ~p_dir_eff[i];
      gpio_pullup_out[i] = ~p_dir_eff[i] & p_out[i];  // [RULE_16]
      if (in_reset) begin
        gpio_oe_n_out[i]   = lcg_pkg::PORT_ONES;  // [RULE_17]
        gpio_pullup_out[i] = lcg_pkg::PORT_ZERO;
        if (mode_now && (3'(i) == lcg_pkg::PORT_C_IDX)) begin
          gpio_out_out[i]  = lcg_pkg::PORT_ZERO;
          gpio_oe_n_out[i] = lcg_pkg::PORT_ZERO;  // [RULE_05]
        end
      end
    end
    // port g: strobes in legacy mode, plain gpio otherwise
    if (mode_now) begin
      portg_oe_n_out   = lcg_pkg::PORTG_LEG_OEN;
      portg_pullup_out = lcg_pkg::PORTG_ZERO;
      portg_out_out    = in_reset ? lcg_pkg::PORTG_LEG_RST  // [RULE_19]
                         : {2'h0, xmem_ale_in, xmem_rd_n_in, xmem_wr_n_in};  // [RULE_06]
    end else if (in_reset) begin
      portg_oe_n_out   = lcg_pkg::PORTG_ONES;  // [RULE_17]
      portg_pullup_out = lcg_pkg::PORTG_ZERO;
      portg_out_out    = g_out;
    end else begin
      portg_oe_n_out   = ~g_dir;
      portg_pullup_out = ~g_dir & g_out;
      portg_out_out    = g_out;
    end
  end

  // control word updates; reset flags keep across reset except on power-on
  always_comb begin
    nxt_rstf    = rstf_ff;
    nxt_baud    = baud_ff;
    nxt_osc     = osc_ff;
    nxt_wdt_en  = wdt_en_ff;
    nxt_wdt_ps  = wdt_ps_ff;
    nxt_wdt_st  = wdt_st_ff;
    nxt_wdt_cnt = wdt_cnt_ff;
    nxt_eint    = eint_ff;
    nxt_xrel    = xrel_ff;
    nxt_xws     = xws_ff;
    // software clears a flag by writing zero to it
    if (wr_go && lane0 && (avs_address_in == lcg_pkg::ADDR_RSTF)) begin
      nxt_rstf = rstf_ff & avs_writedata_in[4:0];
    end
    // a new reset cause wins over a clear in the same cycle
    nxt_rstf = nxt_rstf | (mode_ff ? (rst_event_in & lcg_pkg::RSTF_LEG_MASK)  // [RULE_11]
                                   : rst_event_in);
    if (rst_event_in.power_on_reset_flag) begin
      nxt_rstf = lcg_pkg::RSTF_ZERO;
      nxt_rstf.power_on_reset_flag = 1'b1;
    end
    if (wr_go && (avs_address_in == lcg_pkg::ADDR_BAUD)) begin
      if (lane0) nxt_baud[7:0] = avs_writedata_in[7:0];
      if (lane1) nxt_baud[11:8] = avs_writedata_in[11:8];
    end
    if (mode_ff) begin
      nxt_baud = nxt_baud & lcg_pkg::BAUD_LEG_MASK;  // [RULE_02]
    end
    if (wr_go && lane0 && !mode_ff && (avs_address_in == lcg_pkg::ADDR_OSC)) begin
      nxt_osc = avs_writedata_in[7:0];  // [RULE_09]
    end
    // watchdog: timed unlock window in normal mode, direct write in legacy mode
    if (wdt_cnt_ff != lcg_pkg::WDT_CNT_ZERO) begin
      nxt_wdt_cnt = wdt_cnt_ff - 3'h1;
    end else begin
      nxt_wdt_st = lcg_pkg::WDT_LOCKED;
    end
    if (wr_go && lane0 && (avs_address_in == lcg_pkg::ADDR_WDT)) begin
      if (mode_ff || (wdt_st_ff == lcg_pkg::WDT_OPEN)) begin
        nxt_wdt_en  = avs_writedata_in[lcg_pkg::WDT_EN_BIT];  // [RULE_12]
        nxt_wdt_ps  = avs_writedata_in[lcg_pkg::WDT_PS_W-1:0];
        nxt_wdt_st  = lcg_pkg::WDT_LOCKED;
        nxt_wdt_cnt = lcg_pkg::WDT_CNT_ZERO;
      end else if (avs_writedata_in[lcg_pkg::WDT_CE_BIT]
                   && avs_writedata_in[lcg_pkg::WDT_EN_BIT]) begin
        nxt_wdt_en  = 1'b1;
        nxt_wdt_st  = lcg_pkg::WDT_OPEN;
        nxt_wdt_cnt = lcg_pkg::WDT_UNLOCK_CYCLES;
      end else if (avs_writedata_in[lcg_pkg::WDT_EN_BIT]) begin
        nxt_wdt_en = 1'b1;  // enabling never needs the unlock
      end
    end
    if (wr_go && lane0 && (avs_address_in == lcg_pkg::ADDR_EINT)) begin
      nxt_eint = avs_writedata_in[lcg_pkg::EINT_W-1:0];
    end
    if (mode_ff) begin
      nxt_eint = lcg_pkg::EINT_RST;  // [RULE_13]
    end
    if (wr_go && lane0 && (avs_address_in == lcg_pkg::ADDR_XMEM)) begin
      nxt_xrel = avs_writedata_in[lcg_pkg::XREL_W-1:0];
      nxt_xws  = avs_writedata_in[lcg_pkg::XMEM_WS_BIT];
    end
    if (mode_ff) begin
      nxt_xrel = lcg_pkg::XREL_RST;  // [RULE_10]
      nxt_xws  = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rstf_ff    <= nxt_rstf;
      baud_ff    <= lcg_pkg::BAUD_RST;
      osc_ff     <= lcg_pkg::OSC_CAL_RST;
      wdt_en_ff  <= 1'b0;
      wdt_ps_ff  <= lcg_pkg::WDT_PS_RST;
      wdt_st_ff  <= lcg_pkg::WDT_LOCKED;
      wdt_cnt_ff <= lcg_pkg::WDT_CNT_ZERO;
      eint_ff    <= lcg_pkg::EINT_RST;
      xrel_ff    <= lcg_pkg::XREL_RST;
      xws_ff     <= 1'b0;
    end else if (ce_in) begin
      rstf_ff    <= nxt_rstf;
      baud_ff    <= nxt_baud;
      osc_ff     <= nxt_osc;
      wdt_en_ff  <= nxt_wdt_en;
      wdt_ps_ff  <= nxt_wdt_ps;
      wdt_st_ff  <= nxt_wdt_st;
      wdt_cnt_ff <= nxt_wdt_cnt;
      eint_ff    <= nxt_eint;
      xrel_ff    <= nxt_xrel;
      xws_ff     <= nxt_xws;
    end
  end

  // read mux; legacy forcing shows in direction and pin reads of ports c and f, not in port g reads
  always_comb begin
    rd_mux = '0;
    if (port_hit && (port_idx == lcg_pkg::PORT_G_IDX)) begin
      case (port_ofs)
        lcg_pkg::OFS_OUT: rd_mux[4:0] = g_out;
        lcg_pkg::OFS_DIR: rd_mux[4:0] = g_dir;
        default:          rd_mux[4:0] = g_pin;
      endcase
    end else if (port_hit) begin
      case (port_ofs)
        lcg_pkg::OFS_OUT: rd_mux[7:0] = p_out[port_idx];
        lcg_pkg::OFS_DIR: rd_mux[7:0] = p_dir_eff[port_idx];
        default:          rd_mux[7:0] = p_pin[port_idx];
      endcase
    end else begin
      case (avs_address_in)
        lcg_pkg::ADDR_MODE: rd_mux[14:0] = {feat_ff, mode_ff};
        lcg_pkg::ADDR_RSTF: rd_mux[4:0]  = rstf_ff;
        lcg_pkg::ADDR_BAUD: rd_mux[11:0] = baud_ff;
        lcg_pkg::ADDR_OSC:  rd_mux[7:0]  = osc_ff;
        lcg_pkg::ADDR_WDT:  rd_mux[4:0]  = {wdt_st_ff, wdt_en_ff, wdt_ps_ff};
        lcg_pkg::ADDR_EINT: rd_mux[7:0]  = eint_ff;
        lcg_pkg::ADDR_XMEM: rd_mux[3:0]  = {xws_ff, xrel_ff};
        default:            rd_mux       = '0;  // unmapped reads return zero
      endcase
    end
  end

  // one wait cycle per access: the request is seen, then acknowledged
  always_comb begin
    nxt_wait  = !(req && wait_ff);
    nxt_rdata = (avs_read_in && wait_ff) ? rd_mux : rdata_ff;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else if (ce_in) begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_waitrequest_out = wait_ff;
  assign avs_readdata_out    = rdata_ff;
  assign features_out        = feat_ff;
  assign baud_div_out        = baud_ff;
  assign osc_cal_out         = osc_ff;
  assign wdt_enable_out      = wdt_en_ff;
  assign wdt_prescale_out    = wdt_ps_ff;
  assign ext_int_sense_out   = eint_ff;
  assign xmem_release_out    = xrel_ff;
  assign xmem_sect_ws_en_out = xws_ff;

endmodule : lcg_compat_top

/* File: hdl/lcg_gpio_port.sv */
// one general-purpose port: output latch, direction latch and sampled pin value
// assumes pins synchronous to the clock and write strobes already gated by mode
`timescale 1ns/100ps
module lcg_gpio_port #(
  parameter int         W       = 8,
  parameter logic [7:0] OUT_RST = 8'h00,
  parameter logic [7:0] DIR_RST = 8'h00
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  input  wire logic         out_we_in,
  input  wire logic         dir_we_in,
  input  wire logic [W-1:0] wdata_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] out_val_out,
  output logic      [W-1:0] dir_val_out,
  output logic      [W-1:0] pin_val_out
);

  logic [W-1:0] out_ff, nxt_out;
  logic [W-1:0] dir_ff, nxt_dir;
  logic [W-1:0] pin_ff, nxt_pin;

  // latches load on their own strobe, pins are sampled every enabled cycle
  always_comb begin
    nxt_out = out_we_in ? wdata_in : out_ff;
    nxt_dir = dir_we_in ? wdata_in : dir_ff;
    nxt_pin = pin_in;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      out_ff <= OUT_RST[W-1:0];
      dir_ff <= DIR_RST[W-1:0];
      pin_ff <= OUT_RST[W-1:0];
    end else if (ce_in) begin
      out_ff <= nxt_out;
      dir_ff <= nxt_dir;
      pin_ff <= nxt_pin;
    end
  end

  assign out_val_out = out_ff;
  assign dir_val_out = dir_ff;
  assign pin_val_out = pin_ff;

endmodule : lcg_gpio_port

/* File: hdl/lcg_pkg.sv */
// constants, field layouts and carrier types for the legacy compatibility port gating block
// assumes one 50 MHz clock, a synchronous active-low reset and an avalon-mm master
//
// What this block does
// RULE_01 - programmed fuse selects legacy reduced feature set
// RULE_02 - legacy: one async-only transceiver, 8-bit divisor
// RULE_03 - legacy: one 16-bit timer, two compares
// RULE_04 - legacy: two-wire serial interface disabled
// RULE_05 - legacy: port c output only, drives through reset
// RULE_06 - legacy: port g alternate functions only
// RULE_07 - legacy: port f digital input only, no drive
// RULE_08 - legacy: boot loader capability disabled
// RULE_09 - legacy: rc oscillator calibration not adjustable
// RULE_10 - legacy: memory keeps address pins, one wait-state
// RULE_11 - legacy: only external and power-on reset flags
// RULE_12 - legacy: watchdog timeout change needs no unlock
// RULE_13 - legacy: external interrupts 3..0 level only
// RULE_14 - legacy: no receive fifo, earlier overrun
// RULE_15 - software writes zero to legacy-unused bits
// RULE_16 - ports a..e 8-bit bidirectional, per-bit pull-ups
// RULE_17 - pins float asynchronously on any reset; in legacy mode port c and port g 2..0 drive through reset
// RULE_18 - legacy: no extended io, legacy ram, vectors
// RULE_19 - legacy: port g 2..0 reset to 0,1,1 async
// RULE_20 - fuse sampled in reset, mode fixed afterwards
package lcg_pkg;

  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int PORT_W    = 8;
  localparam int NUM_PORTS = 6;
  localparam int PORTG_W   = 5;
  localparam int STROBE_W  = 3;
  localparam int BAUD_W    = 12;
  localparam int WDT_PS_W  = 3;
  localparam int EINT_W    = 8;
  localparam int XREL_W    = 3;

  // port indices inside the a..g register window
  localparam logic [2:0] PORT_C_IDX = 3'h2;
  localparam logic [2:0] PORT_F_IDX = 3'h5;
  localparam logic [2:0] PORT_G_IDX = 3'h6;

  // per-port word select, byte address bits 3:2
  localparam logic [1:0] OFS_OUT = 2'h0;
  localparam logic [1:0] OFS_DIR = 2'h1;
  localparam logic [1:0] OFS_PIN = 2'h2;

  // byte addresses of the control words
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h80;
  localparam logic [ADDR_W-1:0] ADDR_RSTF = 8'h84;
  localparam logic [ADDR_W-1:0] ADDR_BAUD = 8'h88;
  localparam logic [ADDR_W-1:0] ADDR_OSC  = 8'h8c;
  localparam logic [ADDR_W-1:0] ADDR_WDT  = 8'h90;
  localparam logic [ADDR_W-1:0] ADDR_EINT = 8'h94;
  localparam logic [ADDR_W-1:0] ADDR_XMEM = 8'h98;

  // reset and mask values
  localparam logic [PORT_W-1:0]   PORT_ZERO     = 8'h00;
  localparam logic [PORT_W-1:0]   PORT_ONES     = 8'hff;
  localparam logic [PORTG_W-1:0]  PORTG_ZERO    = 5'h00;
  localparam logic [PORTG_W-1:0]  PORTG_ONES    = 5'h1f;
  localparam logic [PORTG_W-1:0]  PORTG_LEG_RST = 5'h03;
  localparam logic [PORTG_W-1:0]  PORTG_LEG_OEN = 5'h18;
  localparam logic [BAUD_W-1:0]   BAUD_RST      = 12'h000;
  localparam logic [BAUD_W-1:0]   BAUD_LEG_MASK = 12'h0ff;
  localparam logic [7:0]          OSC_CAL_RST   = 8'h80;
  localparam logic [WDT_PS_W-1:0] WDT_PS_RST    = 3'h0;
  localparam logic [EINT_W-1:0]   EINT_RST      = 8'h00;
  localparam logic [XREL_W-1:0]   XREL_RST      = 3'h0;

  // watchdog control word fields
  localparam int WDT_CE_BIT = 4;
  localparam int WDT_EN_BIT = 3;
  localparam logic [2:0] WDT_UNLOCK_CYCLES = 3'h4;
  localparam logic [2:0] WDT_CNT_ZERO      = 3'h0;
  localparam int XMEM_WS_BIT = 3;

  // reset source flags, bit 4 downward
  typedef struct packed {
    logic jtag;
    logic wdt;
    logic brown_out;
    logic external_reset_flag;
    logic power_on_reset_flag;
  } lcg_rst_flags_t;

  localparam logic [4:0] RSTF_ZERO     = 5'h00;
  localparam logic [4:0] RSTF_LEG_MASK = 5'h03;

  // feature enables handed to the surrounding peripherals
  typedef struct packed {
    logic ext_io_en;
    logic ext_vectors_en;
    logic usart1_en;
    logic usart_sync_en;
    logic timer_b_en;
    logic compare_c_en;
    logic twi_en;
    logic boot_en;
    logic osc_adj_en;
    logic xmem_release_en;
    logic xmem_sect_ws_en;
    logic wdt_timed_seq;
    logic eint_edge_en;
    logic rx_fifo_en;
  } lcg_features_t;

  localparam logic [13:0] FEAT_NORMAL = 14'h3fff;
  localparam logic [13:0] FEAT_LEGACY = 14'h0000;

  // watchdog unlock window
  typedef enum logic {
    WDT_LOCKED = 1'b0,
    WDT_OPEN   = 1'b1
  } lcg_wdt_state_t;

endpackage : lcg_pkg

/* File: verification/lcg_compat_checker.sv */
// checker: mode gating relations seen at the top-level ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module lcg_compat_checker (
  input wire logic                              mclk_in,
  input wire logic                              rst_n_in,
  input wire logic                              ce_in,
  input wire logic                              legacy_compat_fuse_in,
  input wire logic                              avs_read_in,
  input wire logic                              avs_write_in,
  input wire logic                              avs_waitrequest_out,
  input wire logic [lcg_pkg::NUM_PORTS-1:0][7:0] gpio_oe_n_out,
  input wire logic [lcg_pkg::PORTG_W-1:0]       portg_oe_n_out,
  input wire lcg_pkg::lcg_features_t            features_out,
  input wire logic [lcg_pkg::BAUD_W-1:0]        baud_div_out,
  input wire logic [lcg_pkg::EINT_W-1:0]        ext_int_sense_out,
  input wire logic [lcg_pkg::XREL_W-1:0]        xmem_release_out,
  input wire logic [7:0]                        osc_cal_out,
  input wire logic                              xmem_sect_ws_en_out
);
  logic mode_ff;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // own copy of the fuse, taken only while reset is held, so a late fuse change is ignored
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in && ce_in) mode_ff <= legacy_compat_fuse_in;
  end
  property p_ans;
    (avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in |=> !avs_waitrequest_out;
  endproperty
  a_ans: assert property (p_ans) else $error("bus request not answered");
  property p_one;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_feat;
    $past(ce_in) && $past(rst_n_in) |-> features_out == (mode_ff ? 14'h0000 : 14'h3fff);
  endproperty
  a_feat: assert property (p_feat) else $error("feature set wrong");
  property p_baud;
    mode_ff |-> baud_div_out[11:8] == 4'h0;
  endproperty
  a_baud: assert property (p_baud) else $error("divisor upper bits live");
  property p_cout;
    mode_ff |-> gpio_oe_n_out[2] == 8'h00;
  endproperty
  a_cout: assert property (p_cout) else $error("port c not driving");
  property p_fin;
    mode_ff |-> gpio_oe_n_out[5] == 8'hff;
  endproperty
  a_fin: assert property (p_fin) else $error("port f drives");
  property p_galt;
    mode_ff |-> portg_oe_n_out == 5'h18;
  endproperty
  a_galt: assert property (p_galt) else $error("port g enables wrong");
  property p_eint;
    mode_ff |-> ext_int_sense_out == 8'h00 && xmem_release_out == 3'h0
                && !xmem_sect_ws_en_out;
  endproperty
  a_eint: assert property (p_eint) else $error("sense or release live");
  // trim writes are dropped in legacy mode, so the value may never move there
  property p_osc;
    mode_ff |-> $stable(osc_cal_out);
  endproperty
  a_osc: assert property (p_osc) else $error("rc trim moved");
endmodule : lcg_compat_checker
bind lcg_compat_top lcg_compat_checker u_chk (.*);

/* File: verification/lcg_pin_model.sv */
// board model: resolves each port pin from drive, pull-up and a wandering level
// assumes oe_n low means the port drives the pin
`timescale 1ns/100ps
module lcg_pin_model (
  input  wire logic                              mclk_in,
  input  wire logic [lcg_pkg::NUM_PORTS-1:0][7:0] out_in,
  input  wire logic [lcg_pkg::NUM_PORTS-1:0][7:0] oe_n_in,
  input  wire logic [lcg_pkg::NUM_PORTS-1:0][7:0] pullup_in,
  output logic      [lcg_pkg::NUM_PORTS-1:0][7:0] pin_out
);
  logic flip_ff = 1'b0;
  // floating lines change every cycle so a stale value can never be read back
  always_ff @(posedge mclk_in) begin
    flip_ff <= ~flip_ff;
  end
  // drive wins, then the pull-up, else the wandering level
  assign pin_out = (~oe_n_in & out_in) | (oe_n_in & (pullup_in | {48{flip_ff}}));
endmodule : lcg_pin_model

/* File: verification/tb_top.sv */
// bench: register bus, reset, fuse and reset events; checks registers and pins
// assumes each bus request is answered one cycle after it is seen
`timescale 1ns/100ps
module tb_top;
  logic            mclk = 1'b0, rst_n = 1'b0, fuse = 1'b0, rd = 1'b0, wr = 1'b0, wreq;
  logic [7:0]      addr = 8'h00;
  logic [31:0]     wdat = 32'h0, rdat, rdata;
  logic [4:0]      ev = 5'h01, gout, goe;
  logic [2:0]      xm = 3'h7;
  logic [5:0][7:0] pout, oe_n, pup, pin;
  int              mismatches = 0, n_checks = 0;
  localparam logic [7:0] TA[10] = '{8'h80, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h24, 8'h54,
                                    8'h64, 8'hfc};
  localparam logic [15:0] TW[10] = '{0, 'hfff, 0, 5, 'hff, 'hf, 0, 'hff, 'hff, 'hff};
  localparam logic [15:0] TN[10] = '{'h7ffe, 'hfff, 0, 0, 'hff, 'hf, 0, 'hff, 'h1f, 0};
  localparam logic [15:0] TL[10] = '{1, 'hff, 'h80, 5, 0, 0, 'hff, 0, 0, 0};
  always #10 mclk = ~mclk;
  lcg_compat_top DUT (.mclk_in(mclk), .rst_n_in(rst_n), .ce_in(1'b1),
    .legacy_compat_fuse_in(fuse), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .gpio_pin_in(pin), .gpio_out_out(pout), .gpio_oe_n_out(oe_n),
    .gpio_pullup_out(pup), .portg_pin_in(5'h00), .portg_out_out(gout), .portg_oe_n_out(goe),
    .portg_pullup_out(), .xmem_wr_n_in(xm[0]), .xmem_rd_n_in(xm[1]), .xmem_ale_in(xm[2]),
    .rst_event_in(ev), .features_out(), .baud_div_out(), .osc_cal_out(), .wdt_enable_out(),
    .wdt_prescale_out(), .ext_int_sense_out(), .xmem_release_out(), .xmem_sect_ws_en_out());
  lcg_pin_model u_board (.mclk_in(mclk), .out_in(pout), .oe_n_in(oe_n), .pullup_in(pup),
    .pin_out(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one access; request held until waitrequest is sampled low, read data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge mclk); while (wreq !== 1'b0);
    rdat = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // pins are looked at 1 ns after reset is asserted, before any edge could have acted
  task automatic reset_dut(input logic f);
    @(posedge mclk);
    fuse <= f;
    rst_n <= 1'b0;
    ev <= {4'h0, !f};
    #1;
    chk(32'(oe_n[1]), 32'hff);
    chk(32'(oe_n[2]), f ? 32'h00 : 32'hff);
    if (f) chk({goe, 3'h0, gout}, {5'h18, 3'h0, 5'h03});
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    ev <= 5'h00;
  endtask : reset_dut
  task automatic t_table(input logic f);
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, TA[i], 32'(TW[i]));
      bus(1'b0, TA[i], 32'h0);
      chk(rdat, 32'(f ? TL[i] : TN[i]));
    end
    // normal mode: open the unlock window, then change the prescaler inside it; legacy mode writes both directly
    bus(1'b1, 8'h90, 32'h18);
    bus(1'b1, 8'h90, 32'h0a);
    bus(1'b0, 8'h90, 32'h0);
    chk(rdat, 32'h0a);
  endtask : t_table
  task automatic t_pins();
    bus(1'b1, 8'h14, 32'hff);
    bus(1'b1, 8'h10, 32'h3c);
    bus(1'b0, 8'h18, 32'h0);
    chk(rdat, 32'h3c);
    bus(1'b1, 8'h14, 32'h0);
    @(negedge mclk);
    chk(32'(pup[1]), 32'h3c);
    bus(1'b1, 8'h14, 32'hff);
  endtask : t_pins
  task automatic t_flags(input logic f);
    @(posedge mclk);
    ev <= f ? 5'h1e : 5'h1c;
    @(posedge mclk);
    ev <= 5'h00;
    bus(1'b0, 8'h84, 32'h0);
    chk(rdat, f ? 32'h02 : 32'h1d);
    bus(1'b1, 8'h84, 32'h0);
  endtask : t_flags
  initial begin
    reset_dut(1'b0);
    t_pins();
    t_flags(1'b0);
    t_table(1'b0);
    reset_dut(1'b1);
    @(posedge mclk);
    fuse <= 1'b0;
    t_table(1'b1);
    t_flags(1'b1);
    xm <= 3'h5;
    @(negedge mclk);
    chk(32'(gout[2:0]), 32'h5);
    conclude();
  end
  // cut a hang well past the expected run of about 190 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    conclude();
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
endmodule : tb_top
